// ---- common/flow_mover_pkg.sv ----
package flow_mover_pkg;
  // channel count and widths
  localparam int NUM_CHAN      = 2;
  localparam int ID_W          = 4;
  localparam int DESC_BYTES    = 5;
  // descriptor byte positions
  localparam logic [2:0] DESC_SRC   = 3'h0;
  localparam logic [2:0] DESC_DST   = 3'h1;
  localparam logic [2:0] DESC_PSIZE = 3'h2;
  localparam logic [2:0] DESC_LENH  = 3'h3;
  localparam logic [2:0] DESC_LENL  = 3'h4;
  // packet size clamp exponent
  localparam logic [7:0] PSIZE_MAX_EXP = 8'h0d;
  // peripheral identifiers
  localparam logic [3:0] PID_RAM   = 4'h0;
  localparam logic [3:0] PID_USB   = 4'h1;
  localparam logic [3:0] PID_AUD1  = 4'h2;
  localparam logic [3:0] PID_AUD2  = 4'h3;
  localparam logic [3:0] PID_PSI   = 4'h4;
  localparam logic [3:0] PID_SPI   = 4'h5;
  localparam logic [3:0] PID_SIO   = 4'h6;
  localparam logic [3:0] PID_NAND  = 4'h7;
  localparam logic [3:0] PID_CARD  = 4'h8;
  localparam logic [3:0] PID_NULL  = 4'hf;
  // crc
  localparam logic [15:0] CRC_POLY  = 16'h8005;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  // channel states
  typedef enum logic [2:0] {
    CH_LOAD = 3'b001,
    CH_RUN  = 3'b010,
    CH_DONE = 3'b100
  } chan_state_t;
endpackage

// ---- common/crc_if.sv ----
interface crc_if;
  import flow_mover_pkg::*;
  logic        byteValid;  // data byte moved on channel 0
  logic [7:0]  byteData;   // that byte
  logic        seedValid;  // load a seed value
  logic [15:0] seedValue;  // seed value
  logic [15:0] crcValue;   // running remainder
  modport mover (output byteValid, byteData, seedValid, seedValue, input crcValue);
  modport crc   (input byteValid, byteData, seedValid, seedValue, output crcValue);
endinterface

// ---- hw/flow_crc16.sv ----
module flow_crc16
  import flow_mover_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  crc_if.crc        port
);
  // shift one byte msb first through the generator
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [15:0] crc_reg;  // remainder

  // remainder update, seed load wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crc_reg <= CRC_RESET;
    end else if (port.seedValid) begin
      crc_reg <= port.seedValue;
    end else if (port.byteValid) begin
      crc_reg <= crcByte(crc_reg, port.byteData);  // see RQ11
    end
  end

  assign port.crcValue = crc_reg;
endmodule

// ---- hw/flow_mover.sv ----
// Overview of operation
// RQ1: two independent source-to-destination channels
// RQ2: control, status, channel control, descriptors, checksum
// RQ3: block idle until enable bit set
// RQ4: software writes descriptor bytewise per channel
// RQ5: full descriptor enables; move when both ready
// RQ6: byte0 source id, byte1 destination id
// RQ7: packet size two power byte2, clamp 8192
// RQ8: bytes3,4 packet count, high byte first
// RQ9: zero count means continuous transfer
// RQ10: peripheral ids decode, 15 null, 9-14 reserved
// RQ11: channel 0 crc16 msb first, optional
// RQ12: null destination always ready, discards data
// RQ13: busy sets on descriptor, clears on end/abort
// RQ14: no priority: channels alternate byte by byte; here channelPriority 1 or 2 favours channel 0 or 1
// RQ15: finite flow end returns channel to idle
// RQ16: packet moves consecutively; count drops per packet
module flow_mover
  import flow_mover_pkg::*;
#(
  parameter int NCH = NUM_CHAN
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        moverEnable,       // mover_enable_bit of flow_control_reg
  input  wire logic        crcEnable,         // checksum enable of flow_control_reg
  input  wire logic [1:0]  channelPriority,   // channel_priority_field
  input  wire logic        abortMode,         // 1 delayed, 0 immediate
  input  wire logic [1:0]  abortReq,          // channel_control_reg abort bits, pulses
  input  wire logic [1:0]  descWrite,         // chan0/chan1_descriptor_port write strobes
  input  wire logic [7:0]  descData,          // descriptor byte
  input  wire logic        crcWrite,          // checksum_data_reg write strobe
  input  wire logic [7:0]  crcWriteData,      // seed byte, msb first
  input  wire logic        crcRead,           // checksum_data_reg read strobe
  input  wire logic [15:0] periphReady,       // ready from each peripheral id
  input  wire logic [7:0]  periphData [16],   // byte offered by each source id
  output logic [1:0]       busyFlag,          // chan0/chan1_busy_flag
  output logic [1:0]       endOfFlow,         // end of flow pulse per channel
  output logic [7:0]       crcReadData,       // checksum byte, msb first
  output logic             moveValid,         // byte moved this cycle
  output logic             moveChannel,       // channel owning the move
  output logic [3:0]       moveSource,        // source id popped
  output logic [3:0]       moveDest,          // destination id pushed
  output logic [7:0]       moveData           // byte on the multimedia bus
);
  initial begin
    if (NCH != 2) $error("flow_mover serves exactly two channels");
  end

  // packet size from exponent, clamped
  function automatic logic [13:0] packetBytes(input logic [7:0] e);
    logic [3:0] x;
    x = (e > PSIZE_MAX_EXP) ? PSIZE_MAX_EXP[3:0] : e[3:0];  // see RQ7
    return 14'(14'h1 << x);
  endfunction

  // null destination always ready, others use their line
  function automatic logic readyOf(input logic [3:0] id, input logic [15:0] rdy);
    return (id == PID_NULL) ? 1'b1 : rdy[id];  // see RQ12 see RQ10
  endfunction

  chan_state_t state_reg [2];     // per-channel state
  logic [2:0]  descIdx_reg [2];   // next descriptor byte
  logic [3:0]  src_reg [2];       // source id
  logic [3:0]  dst_reg [2];       // destination id
  logic [7:0]  psize_reg [2];     // exponent
  logic [15:0] length_reg [2];    // remaining packets
  logic        cont_reg [2];      // continuous mode
  logic [13:0] byteCnt_reg [2];   // bytes done in packet
  logic        stopPkt_reg [2];   // delayed abort pending
  logic        lastGrant_reg;     // alternation memory
  logic [7:0]  seedHi_reg;        // first seed byte
  logic        seedPhase_reg;     // second seed byte expected
  logic        readPhase_reg;     // next read is low byte
  logic [1:0]  chReady;           // channel can move a byte
  logic [1:0]  grant;             // channel granted this cycle
  logic [1:0]  pktEnd;            // granted byte ends packet
  logic [1:0]  flowEnd;           // granted byte ends flow

  crc_if crcBus ();

  flow_crc16 u_crc (
    .clock (clock),
    .rst   (rst),
    .port  (crcBus.crc)
  );

  // readiness and arbitration
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      chReady[c] = moverEnable && state_reg[c] == CH_RUN
                   && readyOf(src_reg[c], periphReady)
                   && readyOf(dst_reg[c], periphReady);  // see RQ3 see RQ5
    end
    grant = 2'h0;
    if (chReady == 2'h3) begin
      if (channelPriority == 2'h1) begin
        grant = 2'h1;  // channel 0 favoured
      end else if (channelPriority == 2'h2) begin
        grant = 2'h2;  // channel 1 favoured
      end else begin
        grant = lastGrant_reg ? 2'h1 : 2'h2;  // see RQ14
      end
    end else begin
      grant = chReady;
    end
    for (int c = 0; c < 2; c++) begin
      pktEnd[c]  = grant[c] && (byteCnt_reg[c] + 14'h1 == packetBytes(psize_reg[c]));
      flowEnd[c] = pktEnd[c] && ((!cont_reg[c] && length_reg[c] == 16'h1) || stopPkt_reg[c]);
    end
  end

  // per-channel descriptor load and transfer, see RQ1
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        state_reg[c]   <= CH_LOAD;
        descIdx_reg[c] <= 3'h0;
        src_reg[c]     <= 4'h0;
        dst_reg[c]     <= 4'h0;
        psize_reg[c]   <= 8'h0;
        length_reg[c]  <= 16'h0;
        cont_reg[c]    <= 1'b0;
        byteCnt_reg[c] <= 14'h0;
        stopPkt_reg[c] <= 1'b0;
      end
      busyFlag  <= 2'h0;
      endOfFlow <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        endOfFlow[c] <= 1'b0;
        case (state_reg[c])
          CH_LOAD: begin
            if (abortReq[c]) begin
              descIdx_reg[c] <= 3'h0;  // abort while loading resets descriptor
            end else if (descWrite[c] && moverEnable) begin  // see RQ4
              case (descIdx_reg[c])
                DESC_SRC:   src_reg[c] <= descData[3:0];  // see RQ6
                DESC_DST:   dst_reg[c] <= descData[3:0];
                DESC_PSIZE: psize_reg[c] <= descData;
                DESC_LENH:  length_reg[c][15:8] <= descData;  // see RQ8
                default:    length_reg[c][7:0] <= descData;
              endcase
              if (descIdx_reg[c] == DESC_LENL) begin
                descIdx_reg[c] <= 3'h0;
                cont_reg[c]    <= ({length_reg[c][15:8], descData} == 16'h0);  // see RQ9
                byteCnt_reg[c] <= 14'h0;
                stopPkt_reg[c] <= 1'b0;
                state_reg[c]   <= CH_RUN;
                busyFlag[c]    <= 1'b1;  // see RQ13
              end else begin
                descIdx_reg[c] <= descIdx_reg[c] + 3'h1;
              end
            end
          end
          CH_RUN: begin
            if (abortReq[c] && !abortMode) begin
              state_reg[c] <= CH_DONE;  // immediate abort after current byte
            end else begin
              if (abortReq[c]) begin
                stopPkt_reg[c] <= 1'b1;  // delayed abort at packet end
              end
              if (grant[c]) begin
                byteCnt_reg[c] <= pktEnd[c] ? 14'h0 : byteCnt_reg[c] + 14'h1;  // see RQ16
                if (pktEnd[c] && !cont_reg[c]) begin
                  length_reg[c] <= length_reg[c] - 16'h1;
                end
                if (flowEnd[c]) begin
                  state_reg[c] <= CH_DONE;
                end
              end
            end
          end
          CH_DONE: begin
            busyFlag[c]  <= 1'b0;  // see RQ13
            endOfFlow[c] <= 1'b1;
            state_reg[c] <= CH_LOAD;  // see RQ15
          end
          default: state_reg[c] <= CH_LOAD;
        endcase
      end
    end
  end

  // alternation memory
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastGrant_reg <= 1'b1;
    end else if (grant != 2'h0) begin
      lastGrant_reg <= grant[1];
    end
  end

  // multimedia bus output stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      moveValid   <= 1'b0;
      moveChannel <= 1'b0;
      moveSource  <= 4'h0;
      moveDest    <= 4'h0;
      moveData    <= 8'h0;
    end else begin
      moveValid   <= grant != 2'h0;
      moveChannel <= grant[1];
      moveSource  <= grant[1] ? src_reg[1] : src_reg[0];
      moveDest    <= grant[1] ? dst_reg[1] : dst_reg[0];
      moveData    <= periphData[grant[1] ? src_reg[1] : src_reg[0]];
    end
  end

  // checksum seed and readback sequencing, see RQ2
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seedHi_reg    <= 8'h0;
      seedPhase_reg <= 1'b0;
      readPhase_reg <= 1'b0;
      crcReadData   <= 8'h0;
    end else if (!crcEnable) begin
      seedPhase_reg <= 1'b0;  // clearing enable restarts byte pairing
      readPhase_reg <= 1'b0;
      crcReadData   <= crcBus.crcValue[15:8];
    end else begin
      if (crcWrite) begin
        seedHi_reg    <= crcWriteData;
        seedPhase_reg <= !seedPhase_reg;
      end
      if (crcRead) begin
        readPhase_reg <= !readPhase_reg;
      end
      crcReadData <= readPhase_reg ? crcBus.crcValue[7:0] : crcBus.crcValue[15:8];
    end
  end

  assign crcBus.seedValid = crcEnable && crcWrite && seedPhase_reg;
  assign crcBus.seedValue = {seedHi_reg, crcWriteData};
  assign crcBus.byteValid = crcEnable && grant[0];  // see RQ11
  assign crcBus.byteData  = periphData[src_reg[0]];
endmodule

// ---- testbench/flow_mover_assertions.sv ----
module flow_mover_assertions
  import flow_mover_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        moverEnable,
  input wire logic [1:0]  descWrite,
  input wire logic [15:0] periphReady,
  input wire logic [1:0]  busyFlag,
  input wire logic [1:0]  endOfFlow,
  input wire logic        moveValid,
  input wire logic        moveChannel,
  input wire logic [3:0]  moveSource,
  input wire logic [3:0]  moveDest
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // busy only follows an accepted descriptor byte
  property p_busy0; $rose(busyFlag[0]) |-> $past(descWrite[0] && moverEnable); endproperty
  a_busy0: assert property (p_busy0) else $error("busy 0 rose without write");
  property p_busy1; $rose(busyFlag[1]) |-> $past(descWrite[1] && moverEnable); endproperty
  a_busy1: assert property (p_busy1) else $error("busy 1 rose without write");
  // end pulse comes with busy falling
  property p_eof; endOfFlow[0] |-> !busyFlag[0] && $past(busyFlag[0]); endproperty
  a_eof: assert property (p_eof) else $error("end pulse without busy drop");
  property p_fall; $fell(busyFlag[1]) |-> endOfFlow[1]; endproperty
  a_fall: assert property (p_fall) else $error("busy fell without end pulse");
  // a move belongs to a busy channel with ready ends
  property p_own; moveValid |-> busyFlag[moveChannel]; endproperty
  a_own: assert property (p_own) else $error("move on idle channel");
  property p_src;
    moveValid && moveSource != PID_NULL
      |-> (($past(periphReady) >> moveSource) & 16'h0001) == 16'h0001;
  endproperty
  a_src: assert property (p_src) else $error("move from stalled source");
  property p_dst;
    moveValid && moveDest != PID_NULL |-> (($past(periphReady) >> moveDest) & 16'h0001) != 0;
  endproperty
  a_dst: assert property (p_dst) else $error("move to stalled sink");
  property p_quiet; busyFlag == 2'b00 |=> !moveValid; endproperty
  a_quiet: assert property (p_quiet) else $error("move while idle");
  c_both: cover property (busyFlag == 2'b11 && moveValid);
  c_null: cover property (moveValid && moveDest == PID_NULL);
  c_end: cover property (endOfFlow[0]);
endmodule
bind flow_mover flow_mover_assertions flow_mover_assertions_i (.clock(clock), .rst(rst),
  .moverEnable(moverEnable), .descWrite(descWrite), .periphReady(periphReady),
  .busyFlag(busyFlag), .endOfFlow(endOfFlow), .moveValid(moveValid),
  .moveChannel(moveChannel), .moveSource(moveSource), .moveDest(moveDest));

// ---- testbench/periph_model.sv ----
module periph_model (
  input  wire logic       clock,
  input  wire logic       slow,   // stall at random
  input  wire logic [7:0] base,   // data seed
  output logic [15:0]     ready,  // ready per id
  output logic [7:0]      data [16]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lfsr = 16'hace1;  // stall pattern
  // pattern moves just after each edge
  always @(posedge clock) lfsr <= #1 {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  assign ready = slow ? lfsr : 16'hffff;
  // a stalled source shows the inverse, not its byte
  for (genvar n = 0; n < 16; n++) begin : g_src
    assign data[n] = ready[n] ? base ^ 8'(n) : ~(base ^ 8'(n));
  end
endmodule

// ---- testbench/tb_top.sv ----
module tb_top;
  import flow_mover_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, moveValid, moveChannel;
  logic        rst = 1'b1, moverEnable = 1'b0, slow = 1'b0;
  logic        crcEnable = 1'b0, crcWrite = 1'b0, crcRead = 1'b0, abortMode = 1'b0;
  logic [1:0]  channelPriority = 0, abortReq = 0, descWrite = 0, busyFlag, endOfFlow;
  logic [7:0]  descData = 0, base = 0, moveData, crcWriteData = 0, crcReadData;
  logic [15:0] periphReady, crcModel = 0;
  logic [7:0]  periphData [16];
  logic [3:0]  moveSource, moveDest, exSrc [2], exDst [2];
  int          bad_count = 0, n_tests = 0, seed = 10, mode = 0, lastCh = 0, cnt [2];
  flow_mover flow_mover_i (.clock(clock), .rst(rst), .moverEnable(moverEnable),
    .crcEnable(crcEnable), .channelPriority(channelPriority), .abortMode(abortMode),
    .abortReq(abortReq), .descWrite(descWrite), .descData(descData), .crcWrite(crcWrite),
    .crcWriteData(crcWriteData), .crcRead(crcRead), .periphReady(periphReady),
    .periphData(periphData), .busyFlag(busyFlag), .endOfFlow(endOfFlow),
    .crcReadData(crcReadData), .moveValid(moveValid), .moveChannel(moveChannel),
    .moveSource(moveSource), .moveDest(moveDest), .moveData(moveData));
  periph_model periph_model_i (.clock(clock), .slow(slow), .base(base),
    .ready(periphReady), .data(periphData));
  // 8 ns clock
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // reference remainder: msb-first division by the generator
  function automatic logic [15:0] crcNext(logic [15:0] c, logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  // model of the bus: every moved byte is checked against its flow
  always @(posedge clock) if (moveValid) begin
    cnt[moveChannel]++;
    chk("data", moveData, base ^ 8'(moveSource));
    chk("src", moveSource, exSrc[moveChannel]);
    chk("dst", moveDest, exDst[moveChannel]);
    if (mode == 1) chk("order", moveChannel, !lastCh);
    if (mode == 2) chk("prio", moveChannel, 0);
    if (mode == 3) chk("prio1", moveChannel, 1);
    if (crcEnable && !moveChannel) crcModel = crcNext(crcModel, moveData);
    lastCh = moveChannel;
  end
  // five descriptor bytes back to back
  task automatic start(int c, logic [3:0] s, logic [3:0] d, logic [7:0] e, logic [15:0] len);
    logic [7:0] b [5];
    b = '{8'(s), 8'(d), e, len[15:8], len[7:0]};
    exSrc[c] = s;
    exDst[c] = d;
    cnt[c] = 0;
    for (int i = 0; i < 5; i++) begin
      descWrite[c] = 1'b1;
      descData = b[i];
      cyc(1);
    end
    descWrite[c] = 1'b0;
    cyc(1);
    chk("busy", busyFlag[c], moverEnable);
  endtask
  // wait for end of flow, then compare the byte count
  task automatic finish(int c, logic [31:0] total);
    int t = 0;
    while (endOfFlow[c] !== 1'b1 && t < 40000) begin
      cyc(1);
      t++;
    end
    chk("bytes", cnt[c], total);
    cyc(1);
    chk("idle", busyFlag[c], 0);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    final_report;
  end
  initial begin
    logic [3:0] ids [10];
    ids = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, PID_NULL};
    base = 8'($random(seed));
    cyc(8);
    rst = 1'b0;
    start(0, 4'h1, PID_NULL, 8'h00, 16'h0001);
    cyc(3);
    chk("off", busyFlag, 0);
    $display("test disabled block done");
    moverEnable = 1'b1;
    cyc(1);
    for (int i = 0; i < 9; i++) begin
      slow = i[0];
      start(i % 2, ids[i], ids[(i + 3) % 10], 8'(i % 3), 16'h0002);
      finish(i % 2, (1 << (i % 3)) * 2);
    end
    $display("test all ids done");
    start(0, 4'h1, PID_NULL, 8'hff, 16'h0001);
    finish(0, 8192);
    start(1, 4'h2, 4'h5, 8'h00, 16'h0102);
    finish(1, 258);
    $display("test clamp and length done");
    // seed the checksum with two random bytes, high first
    crcEnable = 1'b1;
    crcWrite = 1'b1;
    crcWriteData = 8'($random(seed));
    crcModel[15:8] = crcWriteData;
    cyc(1);
    crcWriteData = 8'($random(seed));
    crcModel[7:0] = crcWriteData;
    cyc(1);
    crcWrite = 1'b0;
    // abort while loading must restart the descriptor at byte 0
    descWrite = 2'b01;
    descData = 8'h09;
    cyc(2);
    descWrite = 2'b00;
    abortReq = 2'b01;
    cyc(1);
    abortReq = 2'b00;
    start(0, 4'h1, PID_NULL, 8'h02, 16'h0002);
    finish(0, 8);
    chk("crc hi", crcReadData, crcModel[15:8]);
    crcRead = 1'b1;
    cyc(1);
    crcRead = 1'b0;
    cyc(1);
    chk("crc lo", crcReadData, crcModel[7:0]);
    crcEnable = 1'b0;
    // delayed abort stops at the end of the current 8-byte packet
    start(1, 4'h2, 4'h5, 8'h03, 16'h0000);
    cyc(3);
    abortMode = 1'b1;
    abortReq = 2'b10;
    cyc(1);
    abortReq = 2'b00;
    finish(1, 8);
    abortMode = 1'b0;
    $display("test checksum and abort modes done");
    start(0, 4'h0, 4'h7, 8'h00, 16'h0000);
    start(1, 4'h3, PID_NULL, 8'h01, 16'h0000);
    cyc(4);
    mode = 1;
    cyc(20);
    mode = 0;
    channelPriority = 2'h1;
    cyc(4);
    mode = 2;
    cyc(20);
    mode = 0;
    channelPriority = 2'h2;
    cyc(4);
    mode = 3;
    cyc(20);
    mode = 0;
    chk("cont", busyFlag, 2'b11);
    abortReq = 2'b11;
    cyc(1);
    abortReq = 2'b00;
    cyc(6);
    chk("abort", busyFlag, 0);
    $display("test sharing and abort done");
    final_report;
  end
endmodule
